// file: src/pps_top.sv
// Peripheral pin select: strap capture, pad routing, GPIO gating.
// Assumes straps held stable across reset and an Avalon-MM master.
//
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module pps_top
  import pps_pkg::*;
#(
  parameter int CB_W = 4,
  parameter int HP_W = 4,
  parameter int SP2_W = 3,
  parameter int UP_W = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [pps_pkg::PPS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pps_pkg::PPS_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pps_pkg::PPS_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Selection pins
  input wire logic cell_bus_select_pad,
  input wire logic pci_select_pin,
  input wire logic serial_port2_select,
  input wire logic autoinit_pad,
  // Peripheral enables
  output logic cell_bus_enable,
  output logic serial_port_one_enable,
  output logic host_port_enable,
  output logic pci_enable,
  output logic serial_port_two_enable,
  output logic eeprom_enable,
  output logic pci_autoinit_start,
  // Cell bus / serial port one shared pads
  input wire logic [CB_W-1:0] cb_pad_in,
  output logic [CB_W-1:0] cb_pad_out,
  output logic [CB_W-1:0] cb_pad_oe,
  input wire logic [CB_W-1:0] sp1_core_out,
  input wire logic [CB_W-1:0] sp1_core_oe,
  output logic [CB_W-1:0] sp1_core_in,
  input wire logic [CB_W-1:0] cell_core_out,
  input wire logic [CB_W-1:0] cell_core_oe,
  output logic [CB_W-1:0] cell_core_in,
  // Standalone cell bus and serial port one pads
  input wire logic cell_solo_out,
  input wire logic cell_solo_core_oe,
  output logic cell_solo_oe,
  input wire logic sp1_solo_out,
  input wire logic sp1_solo_core_oe,
  output logic sp1_solo_oe,
  // Host / PCI shared pads
  input wire logic [HP_W-1:0] hp_pad_in,
  output logic [HP_W-1:0] hp_pad_out,
  output logic [HP_W-1:0] hp_pad_oe,
  input wire logic [HP_W-1:0] host_core_out,
  input wire logic [HP_W-1:0] host_core_oe,
  output logic [HP_W-1:0] host_core_in,
  input wire logic [HP_W-1:0] pci_core_out,
  input wire logic [HP_W-1:0] pci_core_oe,
  output logic [HP_W-1:0] pci_core_in,
  // Serial port two / PCI shared pads
  input wire logic [SP2_W-1:0] s2_pad_in,
  output logic [SP2_W-1:0] s2_pad_out,
  output logic [SP2_W-1:0] s2_pad_oe,
  input wire logic [SP2_W-1:0] sp2_core_out,
  input wire logic [SP2_W-1:0] sp2_core_oe,
  output logic [SP2_W-1:0] sp2_core_in,
  input wire logic [SP2_W-1:0] pci_s2_out,
  input wire logic [SP2_W-1:0] pci_s2_oe,
  output logic [SP2_W-1:0] pci_s2_in,
  // Standalone PCI pads: byte enable zero, EEPROM chip select
  input wire logic pci_byte_enable_zero,
  input wire logic eeprom_chip_select,
  input wire logic [1:0] pci_solo_core_oe,
  output logic [1:0] pci_solo_pad_out,
  output logic [1:0] pci_solo_pad_oe,
  // Upper general pins / PCI
  input wire logic [UP_W-1:0] upper_pad_in,
  output logic [UP_W-1:0] upper_pad_out,
  output logic [UP_W-1:0] upper_pad_oe,
  input wire logic [UP_W-1:0] pci_gp_out,
  input wire logic [UP_W-1:0] pci_gp_oe,
  output logic [UP_W-1:0] pci_gp_in,
  // General pin eight / port-two clock source
  input wire logic gp8_pad_in,
  output logic gp8_pad_out,
  output logic gp8_pad_oe,
  output logic serial_port2_clock_source,
  // Lower general pins
  input wire logic [pps_pkg::PPS_GP_EIGHT-1:0] lower_pad_in,
  output logic [pps_pkg::PPS_GP_EIGHT-1:0] lower_pad_out,
  output logic [pps_pkg::PPS_GP_EIGHT-1:0] lower_pad_oe
);
  import pps_pkg::*;

  // ============================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ============================================================
  // Pin synchronisers, no reset so straps flow in during reset
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [PPS_GP_W-1:0] gp_meta;
  logic [PPS_GP_W-1:0] gp_sync;
  always_ff @(posedge mclk) begin
    pin_meta <= {autoinit_pad, serial_port2_select, pci_select_pin, cell_bus_select_pad};
    pin_sync <= pin_meta;
    gp_meta <= {upper_pad_in, gp8_pad_in, lower_pad_in};
    gp_sync <= gp_meta;
  end

  // ============================================================
  // Strap capture
  // Captured on the first edge after internal release, so levels held
  // through reset are the ones kept; later pin moves are ignored, except by the live port-two select.
  logic cfg_done;
  logic cfg_cell_bus;
  logic cfg_pci;
  logic cfg_sp2;
  logic cfg_autoinit;
  logic sp2_live;
  logic next_autoinit;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done <= 1'b0;
      cfg_cell_bus <= 1'b0;
      cfg_pci <= 1'b0;
      cfg_sp2 <= 1'b0;
      cfg_autoinit <= 1'b0;
      pci_autoinit_start <= 1'b0;
    end else begin
      pci_autoinit_start <= next_autoinit;
      if (!cfg_done) begin
        cfg_done <= 1'b1;
        {cfg_autoinit, cfg_sp2, cfg_pci, cfg_cell_bus} <= pin_sync;
      end
    end
  end
  assign next_autoinit = !cfg_done && pin_sync[1] && !pin_sync[2] && pin_sync[3];
  // Port-two select stays live after reset; PCI select does not
  assign sp2_live = cfg_done ? pin_sync[2] : 1'b0;

  // ============================================================
  // Peripheral decode
  assign cell_bus_enable = cfg_cell_bus;
  assign serial_port_one_enable = !cfg_cell_bus;
  assign pci_enable = cfg_pci;
  assign host_port_enable = !cfg_pci;
  assign serial_port_two_enable = !(cfg_pci && !sp2_live);
  assign eeprom_enable = cfg_pci && !sp2_live;

  // ============================================================
  // Shared pad groups
  pps_mux_if #(.W(CB_W)) cb_if ();
  pps_mux_if #(.W(HP_W)) hp_if ();
  pps_mux_if #(.W(SP2_W)) s2_if ();
  assign cb_if.sel = cfg_cell_bus;
  assign cb_if.a_out = sp1_core_out;
  assign cb_if.a_oe = sp1_core_oe;
  assign cb_if.b_out = cell_core_out;
  assign cb_if.b_oe = cell_core_oe;
  assign cb_if.pad_in = cb_pad_in;
  assign sp1_core_in = cb_if.a_in;
  assign cell_core_in = cb_if.b_in;
  assign cb_pad_out = cb_if.pad_out;
  assign cb_pad_oe = cb_if.pad_oe;
  assign hp_if.sel = cfg_pci;
  assign hp_if.a_out = host_core_out;
  assign hp_if.a_oe = host_core_oe;
  assign hp_if.b_out = pci_core_out;
  assign hp_if.b_oe = pci_core_oe;
  assign hp_if.pad_in = hp_pad_in;
  assign host_core_in = hp_if.a_in;
  assign pci_core_in = hp_if.b_in;
  assign hp_pad_out = hp_if.pad_out;
  assign hp_pad_oe = hp_if.pad_oe;
  assign s2_if.sel = eeprom_enable;
  assign s2_if.a_out = sp2_core_out;
  assign s2_if.a_oe = sp2_core_oe;
  assign s2_if.b_out = pci_s2_out;
  assign s2_if.b_oe = pci_s2_oe;
  assign s2_if.pad_in = s2_pad_in;
  assign sp2_core_in = s2_if.a_in;
  assign pci_s2_in = s2_if.b_in;
  assign s2_pad_out = s2_if.pad_out;
  assign s2_pad_oe = s2_if.pad_oe;
  pps_pad_mux u_cb_mux (.m(cb_if.mux));
  pps_pad_mux u_hp_mux (.m(hp_if.mux));
  pps_pad_mux u_s2_mux (.m(s2_if.mux));

  // ============================================================
  // Standalone pads, unselected owner held Hi-Z
  assign cell_solo_oe = cfg_cell_bus && cell_solo_core_oe;
  assign sp1_solo_oe = !cfg_cell_bus && sp1_solo_core_oe;
  assign pci_solo_pad_out = {eeprom_chip_select, pci_byte_enable_zero};
  assign pci_solo_pad_oe = cfg_pci ? pci_solo_core_oe : 2'h0;

  // ============================================================
  // General pin registers
  logic [PPS_GP_W-1:0] gp_enable;
  logic [PPS_GP_W-1:0] gp_direction;
  logic [PPS_GP_W-1:0] gp_out;
  logic [PPS_GP_W-1:0] gp_drive;
  assign gp_drive = gp_enable & gp_direction;
  // Upper pins: PCI owns them, else software enable and direction
  assign upper_pad_out = cfg_pci ? pci_gp_out : gp_out[PPS_GP_W-1:PPS_GP_UPPER_LO];
  assign upper_pad_oe = cfg_pci ? pci_gp_oe : gp_drive[PPS_GP_W-1:PPS_GP_UPPER_LO];
  assign pci_gp_in = cfg_pci ? upper_pad_in : '0;
  // Pin eight defaults to the port-two clock source input
  assign gp8_pad_out = gp_out[PPS_GP_EIGHT];
  assign gp8_pad_oe = gp_drive[PPS_GP_EIGHT];
  assign serial_port2_clock_source = gp_enable[PPS_GP_EIGHT] ? 1'b0 : gp8_pad_in;
  // Lower pins ignore every strap
  assign lower_pad_out = gp_out[PPS_GP_EIGHT-1:0];
  assign lower_pad_oe = gp_drive[PPS_GP_EIGHT-1:0];

  // ============================================================
  // Avalon-MM slave, one wait state on every access
  logic bus_ack;
  logic bus_req;
  logic wr_take;
  logic [PPS_DW-1:0] cfg_word;
  logic [PPS_DW-1:0] rd_mux;
  logic [PPS_DW-1:0] wr_mask;
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !bus_ack;
  assign wr_take = avs_write && bus_ack;
  assign wr_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cfg_word = {25'h000_0000, cfg_done, eeprom_enable, sp2_live, cfg_autoinit, cfg_sp2, cfg_pci, cfg_cell_bus};
  // Unmapped addresses read zero and drop writes
  assign rd_mux = (avs_address == PPS_OFS_CONFIG) ? cfg_word :
                  (avs_address == PPS_OFS_GP_ENABLE) ? {16'h0000, gp_enable} :
                  (avs_address == PPS_OFS_GP_DIRECTION) ? {16'h0000, gp_direction} :
                  (avs_address == PPS_OFS_GP_OUT) ? {16'h0000, gp_out} :
                  (avs_address == PPS_OFS_GP_IN) ? {16'h0000, gp_sync} : 32'h0000_0000;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req && !bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= rd_mux;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gp_enable <= PPS_GP_RESET;
      gp_direction <= PPS_GP_RESET;
      gp_out <= PPS_GP_RESET;
    end else if (wr_take) begin
      if (avs_address == PPS_OFS_GP_ENABLE) begin
        gp_enable <= (gp_enable & ~wr_mask[15:0]) | (avs_writedata[15:0] & wr_mask[15:0]);
      end
      if (avs_address == PPS_OFS_GP_DIRECTION) begin
        gp_direction <= (gp_direction & ~wr_mask[15:0]) | (avs_writedata[15:0] & wr_mask[15:0]);
      end
      if (avs_address == PPS_OFS_GP_OUT) begin
        gp_out <= (gp_out & ~wr_mask[15:0]) | (avs_writedata[15:0] & wr_mask[15:0]);
      end
    end
  end

  // ============================================================
  // Checks
  default clocking cb_chk @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_sel_rise;
    cfg_done && $rose(serial_port2_select);
  endsequence
  sequence s_sel_held;
    serial_port2_select [*3];
  endsequence
  a_config_hold: assert property (cfg_done && $past(cfg_done) |-> $stable(cfg_pci) && $stable(cfg_cell_bus))
    else $error("Captured straps moved after capture");
  a_sp1_default: assert property (!cfg_cell_bus |-> serial_port_one_enable && !cell_bus_enable && !cell_solo_oe)
    else $error("Serial port one not owning shared pins");
  a_cell_bus_on: assert property (cfg_cell_bus |-> cb_pad_oe == cell_core_oe && !sp1_solo_oe)
    else $error("Cell bus not owning shared pins");
  a_sp2_off_case: assert property (serial_port_two_enable == !(cfg_pci && !sp2_live))
    else $error("Port two enable decode wrong");
  a_autoinit_once: assert property (pci_autoinit_start |-> cfg_pci && !cfg_sp2 && cfg_autoinit ##1 !pci_autoinit_start)
    else $error("Autoinit pulse without its straps");
  a_sp2_raise: assert property (s_sel_rise ##0 s_sel_held |-> ##[0:1] (serial_port_two_enable && !eeprom_enable))
    else $error("Port two not enabled after select raised");
  a_sync_delay: assert property (cfg_done && $past(cfg_done, 3) |-> sp2_live == $past(serial_port2_select, 2))
    else $error("Port two select not two flops deep");
  a_host_default: assert property (!cfg_pci |-> host_port_enable && pci_solo_pad_oe == 2'h0 && hp_pad_oe == host_core_oe)
    else $error("Host port routing or PCI Hi-Z wrong");
  a_upper_gate: assert property (!cfg_pci && !gp_enable[PPS_GP_UPPER_LO] |-> !upper_pad_oe[0])
    else $error("Upper pin driven without enable");
  a_pci_owns: assert property (cfg_pci |-> !host_port_enable && upper_pad_oe == pci_gp_oe && hp_pad_oe == pci_core_oe)
    else $error("PCI not owning shared pins");
  a_gp8_default: assert property (!gp_enable[PPS_GP_EIGHT] |-> !gp8_pad_oe && serial_port2_clock_source == gp8_pad_in)
    else $error("Pin eight not clock source by default");
  a_lower_free: assert property (wr_take && avs_address == PPS_OFS_GP_OUT && avs_byteenable[0] |=> lower_pad_out == $past(avs_writedata[7:0]))
    else $error("Lower pins not following software");
  a_bus_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Wait state longer than one cycle");
endmodule

// file: src/pps_pkg.sv
// Constants for the peripheral pin select block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package pps_pkg;
  // ============================================================
  // Bus
  localparam int PPS_AW = 5;
  localparam int PPS_DW = 32;
  localparam logic [PPS_AW-1:0] PPS_OFS_CONFIG = 5'h00;
  localparam logic [PPS_AW-1:0] PPS_OFS_GP_ENABLE = 5'h04;
  localparam logic [PPS_AW-1:0] PPS_OFS_GP_DIRECTION = 5'h08;
  localparam logic [PPS_AW-1:0] PPS_OFS_GP_OUT = 5'h0C;
  localparam logic [PPS_AW-1:0] PPS_OFS_GP_IN = 5'h10;
  // ============================================================
  // General pins
  localparam int PPS_GP_W = 16;
  localparam int PPS_GP_EIGHT = 8;
  localparam int PPS_GP_UPPER_LO = 9;
  localparam logic [PPS_GP_W-1:0] PPS_GP_RESET = 16'h0000;
  // ============================================================
  // Config status bits
  localparam int PPS_CFG_CELL_BUS = 0;
  localparam int PPS_CFG_PCI = 1;
  localparam int PPS_CFG_SP2_STRAP = 2;
  localparam int PPS_CFG_AUTOINIT = 3;
  localparam int PPS_CFG_SP2_LIVE = 4;
  localparam int PPS_CFG_EEPROM = 5;
  localparam int PPS_CFG_DONE = 6;
endpackage

// file: src/pps_mux_if.sv
// Carrier between the pin-select top and its pad mux.
// Assumes pad levels are resolved by the surrounding pad ring.
`timescale 1ns/1ps
interface pps_mux_if #(parameter int W = 4);
  logic sel;
  logic [W-1:0] a_out;
  logic [W-1:0] a_oe;
  logic [W-1:0] a_in;
  logic [W-1:0] b_out;
  logic [W-1:0] b_oe;
  logic [W-1:0] b_in;
  logic [W-1:0] pad_in;
  logic [W-1:0] pad_out;
  logic [W-1:0] pad_oe;
  modport mux (input sel, a_out, a_oe, b_out, b_oe, pad_in, output a_in, b_in, pad_out, pad_oe);
  modport user (output sel, a_out, a_oe, b_out, b_oe, pad_in, input a_in, b_in, pad_out, pad_oe);
endinterface

// file: src/pps_pad_mux.sv
// Two-way selector of one shared pad group between two owners.
// Assumes sel is stable or changes only on a clean clock edge.
`timescale 1ns/1ps
module pps_pad_mux (
  // Carrier
  pps_mux_if.mux m
);
  // ============================================================
  // Selection, sel high gives the pads to owner b
  // Unselected owner sees zeros so it cannot act on foreign traffic
  assign m.pad_out = m.sel ? m.b_out : m.a_out;
  assign m.pad_oe = m.sel ? m.b_oe : m.a_oe;
  assign m.a_in = m.sel ? '0 : m.pad_in;
  assign m.b_in = m.sel ? m.pad_in : '0;
endmodule

// file: tb/pps_board_model.sv
// Board side of the selection pins: pull resistors or logic driving straps.
// Assumes the bench states the wanted levels and owns the device reset.
`timescale 1ns/1ps
module pps_board_model (
  // Clock, reset and wanted levels {autoinit, port two, pci, cell bus}
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] want,
  // Selection pins
  output logic cell_bus_select_pad,
  output logic pci_select_pin,
  output logic serial_port2_select,
  output logic autoinit_pad
);
  // ============================================================
  // Strap drive
  // Pins always driven valid, never floating
  initial begin
    cell_bus_select_pad = 1'b0;
    pci_select_pin = 1'b0;
    serial_port2_select = 1'b0;
    autoinit_pad = 1'b0;
  end
  always @(posedge mclk) begin
    // PCI select only moves while the device sits in reset
    if (!arst_n) begin
      pci_select_pin <= want[1];
      autoinit_pad <= want[3] & want[1];
    end
    cell_bus_select_pad <= want[0];
    // Port-two select may move while running
    serial_port2_select <= want[2];
  end
endmodule

// file: tb/tb_pps_top.sv
// Self-checking bench for the peripheral pin select block.
// Assumes the package offsets and the one-wait-state Avalon-MM slave.
`timescale 1ns/1ps
module tb_pps_top;
  import pps_pkg::*;
  // ============================================================
  // Signals
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  logic [3:0] want = 4'h0;
  logic cell_bus_select_pad, pci_select_pin, serial_port2_select, autoinit_pad;
  logic cell_bus_enable, serial_port_one_enable, host_port_enable, pci_enable;
  logic serial_port_two_enable, eeprom_enable, pci_autoinit_start;
  logic [3:0] cb_pad_in = 4'h9, sp1_core_out = 4'h5, sp1_core_oe = 4'h3, cell_core_out = 4'ha, cell_core_oe = 4'hc;
  logic [3:0] cb_pad_out, cb_pad_oe, sp1_core_in, cell_core_in;
  logic cell_solo_out = 1'b1, cell_solo_core_oe = 1'b1, sp1_solo_out = 1'b0, sp1_solo_core_oe = 1'b1;
  logic cell_solo_oe, sp1_solo_oe;
  logic [3:0] hp_pad_in = 4'h3, host_core_out = 4'h6, host_core_oe = 4'hf, pci_core_out = 4'h9, pci_core_oe = 4'he;
  logic [3:0] hp_pad_out, hp_pad_oe, host_core_in, pci_core_in;
  logic [2:0] s2_pad_in = 3'h5, sp2_core_out = 3'h1, sp2_core_oe = 3'h7, pci_s2_out = 3'h6, pci_s2_oe = 3'h3;
  logic [2:0] s2_pad_out, s2_pad_oe, sp2_core_in, pci_s2_in;
  logic pci_byte_enable_zero = 1'b1, eeprom_chip_select = 1'b0;
  logic [1:0] pci_solo_core_oe = 2'h3, pci_solo_pad_out, pci_solo_pad_oe;
  logic [6:0] upper_pad_in = 7'h2a, pci_gp_out = 7'h55, pci_gp_oe = 7'h7f;
  logic [6:0] upper_pad_out, upper_pad_oe, pci_gp_in;
  logic gp8_pad_in = 1'b1, gp8_pad_out, gp8_pad_oe, serial_port2_clock_source;
  logic [7:0] lower_pad_in = 8'h3c, lower_pad_out, lower_pad_oe;
  logic c, p, s, e;
  int n_errors = 0;
  int n_checks = 0;
  int n_pulse = 0;
  // ============================================================
  // Instances
  pps_board_model u_pps_board_model (.mclk, .arst_n, .want, .cell_bus_select_pad, .pci_select_pin,
    .serial_port2_select, .autoinit_pad);
  pps_top u_pps_top (.mclk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .cell_bus_select_pad, .pci_select_pin, .serial_port2_select, .autoinit_pad,
    .cell_bus_enable, .serial_port_one_enable, .host_port_enable, .pci_enable, .serial_port_two_enable,
    .eeprom_enable, .pci_autoinit_start, .cb_pad_in, .cb_pad_out, .cb_pad_oe, .sp1_core_out, .sp1_core_oe,
    .sp1_core_in, .cell_core_out, .cell_core_oe, .cell_core_in, .cell_solo_out, .cell_solo_core_oe,
    .cell_solo_oe, .sp1_solo_out, .sp1_solo_core_oe, .sp1_solo_oe, .hp_pad_in, .hp_pad_out, .hp_pad_oe,
    .host_core_out, .host_core_oe, .host_core_in, .pci_core_out, .pci_core_oe, .pci_core_in, .s2_pad_in,
    .s2_pad_out, .s2_pad_oe, .sp2_core_out, .sp2_core_oe, .sp2_core_in, .pci_s2_out, .pci_s2_oe, .pci_s2_in,
    .pci_byte_enable_zero, .eeprom_chip_select, .pci_solo_core_oe, .pci_solo_pad_out, .pci_solo_pad_oe,
    .upper_pad_in, .upper_pad_out, .upper_pad_oe, .pci_gp_out, .pci_gp_oe, .pci_gp_in, .gp8_pad_in,
    .gp8_pad_out, .gp8_pad_oe, .serial_port2_clock_source, .lower_pad_in, .lower_pad_out, .lower_pad_oe);
  // ============================================================
  // Clock and helpers
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (pci_autoinit_start === 1'b1) begin
      n_pulse++;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      final_report();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Straps set while in reset and held well past the capture edge
  task automatic boot(input logic [3:0] v);
    want <= v;
    arst_n <= 1'b0;
    n_pulse = 0;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ============================================================
  // Tests
  initial begin
    #20_000;
    n_errors++;
    final_report();
  end
  initial begin
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      c = i[0];
      p = i[1];
      s = i[2];
      e = p & !s;
      boot({1'b1, s, p, c});
      chk({cell_bus_enable, serial_port_one_enable}, {c, !c});
      chk(cb_pad_out, c ? 4'ha : 4'h5);
      chk(cell_core_in, c ? 4'h9 : 4'h0);
      chk({cell_solo_oe, sp1_solo_oe}, {c, !c});
      chk({host_port_enable, pci_enable}, {!p, p});
      chk(hp_pad_out, p ? 4'h9 : 4'h6);
      chk(pci_solo_pad_oe, {p, p});
      chk({upper_pad_out, upper_pad_oe}, p ? 14'h2aff : 14'h0000);
      chk({serial_port_two_enable, eeprom_enable}, {!e, e});
      chk(s2_pad_out, e ? 3'h6 : 3'h1);
      chk(n_pulse, e);
      chk({sp1_core_in, host_core_in, pci_core_in}, {c ? 4'h0 : 4'h9, p ? 4'h0 : 4'h3, p ? 4'h3 : 4'h0});
      chk({sp2_core_in, pci_s2_in, pci_gp_in}, {e ? 3'h0 : 3'h5, e ? 3'h5 : 3'h0, p ? 7'h2a : 7'h00});
      chk({cb_pad_oe, pci_solo_pad_out}, {c ? 4'hc : 4'h3, 2'h1});
      chk({hp_pad_oe, s2_pad_oe}, {p ? 4'he : 4'hf, e ? 3'h3 : 3'h7});
      bus(1'b0, PPS_OFS_CONFIG, 32'h0000_0000);
      chk(rd, {25'h0, 1'b1, e, s, p, s, p, c});
      // The cell-bus strap pin moved after release must not change anything; a raised port-two select must
      want[0] <= !c;
      repeat (5) @(posedge mclk);
      chk(cell_bus_enable, c);
      if (e) begin
        want[2] <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({serial_port_two_enable, eeprom_enable, s2_pad_out}, 5'b10001);
      end
    end
    $display("strap table test done");
    for (int k = 0; k < 2; k++) begin
      p = k[0];
      boot({1'b0, 1'b1, p, 1'b0});
      chk(serial_port2_clock_source, 1'b1);
      bus(1'b1, PPS_OFS_GP_OUT, 32'h0000_a5c3);
      bus(1'b1, PPS_OFS_GP_ENABLE, 32'hffff_ffff);
      bus(1'b1, PPS_OFS_GP_DIRECTION, 32'h0000_81f0);
      bus(1'b1, PPS_OFS_CONFIG, 32'h0000_0000);
      bus(1'b0, PPS_OFS_GP_ENABLE, 32'h0000_0000);
      chk(rd, 32'h0000_ffff);
      chk({lower_pad_out, lower_pad_oe}, 16'hc3f0);
      chk({gp8_pad_out, gp8_pad_oe, serial_port2_clock_source}, 3'b110);
      chk({upper_pad_out, upper_pad_oe}, p ? 14'h2aff : {7'h52, 7'h40});
      bus(1'b0, PPS_OFS_GP_IN, 32'h0000_0000);
      chk(rd, 32'h0000_553c);
      bus(1'b0, 5'h14, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      bus(1'b0, PPS_OFS_CONFIG, 32'h0000_0000);
      chk(rd[3:0], {1'b0, 1'b1, p, 1'b0});
    end
    $display("general pin test done");
    final_report();
  end
endmodule
